// ==== verilog/acp_pkg.sv ====
`default_nettype none
package acp_pkg;
  // register byte offsets
  localparam logic [11:0] ACP_OFF_PRESCALE = 12'h03c;
  localparam logic [11:0] ACP_OFF_TRIM_CTRL = 12'h040;
  localparam logic [11:0] ACP_OFF_TRIM_CNT = 12'h044;
  localparam logic [11:0] ACP_OFF_IRQ_STATUS = 12'h048;
  localparam logic [11:0] ACP_OFF_IRQ_MASK = 12'h04c;
  localparam int ACP_ADDR_W = 12;

  // reset values
  localparam logic [31:0] ACP_RST_PRESCALE = 32'h0000_0000;
  localparam logic [2:0] ACP_RST_IRQ_MASK = 3'h0;

  // prescale register field positions (lsb of each 2-bit select)
  localparam int ACP_NUM_STD = 8;
  localparam int ACP_POS_AUDIO = 20;
  localparam int ACP_POS_SC1 = 18;
  localparam int ACP_POS_SC0 = 16;
  localparam int ACP_POS_BACKUP = 14;
  localparam int ACP_POS_WDOG = 12;
  localparam int ACP_POS_CMP = 8;
  localparam int ACP_POS_ADC = 4;
  localparam int ACP_POS_EXTI = 2;
  localparam int ACP_POS_AFIO = 0;
  // writable bits of the prescale register, the rest reads as zero
  localparam logic [31:0] ACP_PRESCALE_WMASK = 32'h003f_f33f;
  // backup access divider starts at divide by 4
  localparam logic [2:0] ACP_BACKUP_BASE_SHIFT = 3'h2;

  // index of each standard select within the clock-enable vector
  localparam int ACP_IDX_AUDIO = 7;
  localparam int ACP_IDX_SC1 = 6;
  localparam int ACP_IDX_SC0 = 5;
  localparam int ACP_IDX_WDOG = 4;
  localparam int ACP_IDX_CMP = 3;
  localparam int ACP_IDX_ADC = 2;
  localparam int ACP_IDX_EXTI = 1;
  localparam int ACP_IDX_AFIO = 0;

  // trim control register fields
  localparam int ACP_POS_COARSE = 24;
  localparam int ACP_POS_FINE = 16;
  localparam int ACP_POS_LOCK = 7;
  localparam int ACP_POS_REFSEL = 5;
  localparam int ACP_POS_MODE = 4;
  localparam int ACP_POS_ATC_EN = 1;
  localparam int ACP_POS_TRIM_EN = 0;
  localparam int ACP_COARSE_W = 5;
  localparam int ACP_FINE_W = 8;
  localparam int ACP_CNT_W = 14;

  // interrupt status bit positions
  localparam int ACP_IRQ_LOCK_GAIN = 0;
  localparam int ACP_IRQ_LOCK_LOSS = 1;
  localparam int ACP_IRQ_FINE_UPD = 2;
  localparam int ACP_IRQ_W = 3;

  // trim mode select
  typedef enum logic {
    ACP_MODE_AUTO = 1'b0,
    ACP_MODE_MANUAL = 1'b1
  } acp_mode_t;

  // reference for the auto-trim controller
  typedef enum logic [1:0] {
    ACP_REF_LOW_SPEED_XTAL = 2'b00,
    ACP_REF_USB_FRAME = 2'b01,
    ACP_REF_EXT_PIN = 2'b10,
    ACP_REF_EXT_PIN_ALT = 2'b11
  } acp_ref_t;

  // settings handed to the oscillator and the auto-trim controller
  typedef struct packed {
    logic [ACP_COARSE_W-1:0] coarse;
    logic [ACP_FINE_W-1:0] fine;
    acp_ref_t ref_sel;
    acp_mode_t mode;
    logic atc_run;
    logic trim_en;
  } acp_trim_t;

  // what the auto-trim controller reports back
  typedef struct packed {
    logic fine_load;
    logic [ACP_FINE_W-1:0] fine_value;
    logic locked;
    logic [ACP_CNT_W-1:0] count;
  } acp_atc_t;
endpackage : acp_pkg
`default_nettype wire

// ==== verilog/acp_clock_prescale_trim.sv ====
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R01: standard selects divide by 1, 2, 4, 8
// R02: bits 21:20 select audio serial clock divider
// R03: bits 19:18 smartcard1, 17:16 smartcard0 dividers
// R04: bits 15:14 backup access divide 4 to 32
// R05: bits 13:12 select watchdog access divider
// R06: bits 9:8 select comparator clock divider
// R07: bits 5:4 select converter controller divider
// R08: bits 3:2 select external interrupt divider
// R09: bits 1:0 select alternate-function io divider
// R10: coarse trim loads factory value, ignores writes
// R11: fine trim loads factory value at startup, as coarse does
// R12: fine trim writable by software and controller
// R13: bit 7 shows frequency lock
// R14: bits 6:5 select auto-trim reference clock
// R15: bit 4 chooses automatic or manual trim
// R16: bit 1 enables auto-trim controller
// R17: bit 0 enables all trimming
// R18: controller updates fine only when fully enabled
// R19: counter register shows 14-bit controller count
module acp_clock_prescale_trim #(
  parameter int DIV_CNT_W = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [acp_pkg::ACP_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [acp_pkg::ACP_COARSE_W-1:0] factory_coarse,
  input wire logic [acp_pkg::ACP_FINE_W-1:0] factory_fine,
  input wire acp_pkg::acp_atc_t atc_status,
  output logic [acp_pkg::ACP_NUM_STD-1:0] periph_clk_en,
  output logic backup_access_clk_en,
  output acp_pkg::acp_trim_t trim_cfg,
  output logic irq
);
  import acp_pkg::*;

  logic [31:0] prescale_q;
  logic [ACP_COARSE_W-1:0] coarse_q;
  logic [ACP_FINE_W-1:0] fine_q;
  acp_ref_t refsel_q;
  acp_mode_t mode_q;
  logic atc_en_q;
  logic trim_en_q;
  logic lock_q;
  logic [ACP_CNT_W-1:0] count_q;
  logic [ACP_IRQ_W-1:0] status_q;
  logic [ACP_IRQ_W-1:0] mask_q;
  logic [ACP_IRQ_W-1:0] rd_snap_q;
  logic startup_q;
  logic [DIV_CNT_W-1:0] div_cnt_q;
  logic [31:0] rdata_d;
  logic mapped_d;
  logic setup;
  logic access;
  logic wr_access;
  logic atc_owns_fine;
  logic [ACP_IRQ_W-1:0] events;
  logic [ACP_IRQ_W-1:0] status_d;
  logic [2:0] std_shift [ACP_NUM_STD];
  logic [2:0] backup_shift;

  // apb phases; write and read-clear take effect only at the access edge
  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign wr_access = access && pwrite;

  // the controller only steers fine trim when every enable agrees
  assign atc_owns_fine = trim_en_q && atc_en_q && (mode_q == ACP_MODE_AUTO); // [R18]

  // factory values are captured by a clocked process once reset is released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      startup_q <= 1'b1;
    end else begin
      startup_q <= 1'b0;
    end
  end

  // prescale selects, plain read/write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_q <= ACP_RST_PRESCALE;
    end else if (wr_access && paddr == ACP_OFF_PRESCALE) begin
      prescale_q <= pwdata & ACP_PRESCALE_WMASK; // [R02] [R03] [R04] [R05] [R06] [R07] [R08] [R09]
    end
  end

  // coarse trim: factory only, a bus write never reaches it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coarse_q <= '0;
    end else if (startup_q) begin
      coarse_q <= factory_coarse; // [R10]
    end
  end

  // fine trim: factory at startup, then controller or software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fine_q <= '0;
    end else if (startup_q) begin
      fine_q <= factory_fine; // [R11]
    end else if (atc_owns_fine && atc_status.fine_load) begin
      fine_q <= atc_status.fine_value; // [R12] [R18]
    end else if (!atc_owns_fine && wr_access && paddr == ACP_OFF_TRIM_CTRL) begin
      fine_q <= pwdata[ACP_POS_FINE +: ACP_FINE_W]; // [R12]
    end
  end

  // trim control bits written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refsel_q <= ACP_REF_LOW_SPEED_XTAL;
      mode_q <= ACP_MODE_AUTO;
      atc_en_q <= 1'b0;
      trim_en_q <= 1'b0;
    end else if (wr_access && paddr == ACP_OFF_TRIM_CTRL) begin
      refsel_q <= acp_ref_t'(pwdata[ACP_POS_REFSEL +: 2]); // [R14]
      mode_q <= acp_mode_t'(pwdata[ACP_POS_MODE]); // [R15]
      atc_en_q <= pwdata[ACP_POS_ATC_EN]; // [R16]
      trim_en_q <= pwdata[ACP_POS_TRIM_EN]; // [R17]
    end
  end

  // lock flag follows the controller only while it runs; the counter snapshot follows it always
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q <= 1'b0;
      count_q <= '0;
    end else begin
      lock_q <= trim_en_q && atc_en_q && atc_status.locked; // [R13]
      count_q <= atc_status.count; // [R19]
    end
  end

  // events: lock gained, lock lost, controller moved the fine trim
  always_comb begin
    events = '0;
    events[ACP_IRQ_LOCK_GAIN] = !lock_q && trim_en_q && atc_en_q && atc_status.locked;
    events[ACP_IRQ_LOCK_LOSS] = lock_q && !(trim_en_q && atc_en_q && atc_status.locked);
    events[ACP_IRQ_FINE_UPD] = !startup_q && atc_owns_fine && atc_status.fine_load;
  end

  // read clears only bits that were seen; a new event always wins
  always_comb begin
    status_d = status_q;
    if (access && !pwrite && paddr == ACP_OFF_IRQ_STATUS) begin
      status_d = status_q & ~rd_snap_q;
    end
    status_d = status_d | events;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  // interrupt mask, same layout as status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= ACP_RST_IRQ_MASK;
    end else if (wr_access && paddr == ACP_OFF_IRQ_MASK) begin
      mask_q <= pwdata[ACP_IRQ_W-1:0];
    end
  end

  // level interrupt from the next status so it tracks status_q exactly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_d & mask_q);
    end
  end

  // read mux, reserved bits zero
  always_comb begin
    rdata_d = '0;
    mapped_d = 1'b1;
    case (paddr)
      ACP_OFF_PRESCALE: begin
        rdata_d = prescale_q;
      end
      ACP_OFF_TRIM_CTRL: begin
        rdata_d[ACP_POS_COARSE +: ACP_COARSE_W] = coarse_q;
        rdata_d[ACP_POS_FINE +: ACP_FINE_W] = fine_q;
        rdata_d[ACP_POS_LOCK] = lock_q; // [R13]
        rdata_d[ACP_POS_REFSEL +: 2] = refsel_q;
        rdata_d[ACP_POS_MODE] = mode_q;
        rdata_d[ACP_POS_ATC_EN] = atc_en_q;
        rdata_d[ACP_POS_TRIM_EN] = trim_en_q;
      end
      ACP_OFF_TRIM_CNT: begin
        rdata_d[ACP_CNT_W-1:0] = count_q; // [R19]
      end
      ACP_OFF_IRQ_STATUS: begin
        rdata_d[ACP_IRQ_W-1:0] = status_q | events;
      end
      ACP_OFF_IRQ_MASK: begin
        rdata_d[ACP_IRQ_W-1:0] = mask_q;
      end
      default: begin
        mapped_d = 1'b0;
      end
    endcase
  end

  // one fixed wait-free access: answer is prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
      rd_snap_q <= '0;
    end else if (setup) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : rdata_d;
      pslverr <= !mapped_d;
      rd_snap_q <= rdata_d[ACP_IRQ_W-1:0];
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // free-running base counter for all dividers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= '0;
    end else begin
      div_cnt_q <= div_cnt_q + 1'b1;
    end
  end

  // divide ratio is a power of two, so the select is a shift amount
  assign std_shift[ACP_IDX_AUDIO] = {1'b0, prescale_q[ACP_POS_AUDIO +: 2]};
  assign std_shift[ACP_IDX_SC1] = {1'b0, prescale_q[ACP_POS_SC1 +: 2]};
  assign std_shift[ACP_IDX_SC0] = {1'b0, prescale_q[ACP_POS_SC0 +: 2]};
  assign std_shift[ACP_IDX_WDOG] = {1'b0, prescale_q[ACP_POS_WDOG +: 2]};
  assign std_shift[ACP_IDX_CMP] = {1'b0, prescale_q[ACP_POS_CMP +: 2]};
  assign std_shift[ACP_IDX_ADC] = {1'b0, prescale_q[ACP_POS_ADC +: 2]};
  assign std_shift[ACP_IDX_EXTI] = {1'b0, prescale_q[ACP_POS_EXTI +: 2]};
  assign std_shift[ACP_IDX_AFIO] = {1'b0, prescale_q[ACP_POS_AFIO +: 2]};
  // backup access runs four times slower than the standard scale
  assign backup_shift = {1'b0, prescale_q[ACP_POS_BACKUP +: 2]} + ACP_BACKUP_BASE_SHIFT; // [R04]

  // an enable fires when the low bits of the counter are all zero
  function automatic logic tick(input logic [DIV_CNT_W-1:0] cnt, input logic [2:0] sh);
    logic [DIV_CNT_W-1:0] low_mask;
    low_mask = DIV_CNT_W'((32'h1 << sh) - 32'h1);
    return (cnt & low_mask) == '0;
  endfunction : tick

  // registered one-cycle enable pulses; divide by 1 holds high
  for (genvar i = 0; i < ACP_NUM_STD; i++) begin : g_std_en
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        periph_clk_en[i] <= 1'b0;
      end else begin
        periph_clk_en[i] <= tick(div_cnt_q, std_shift[i]); // [R01]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      backup_access_clk_en <= 1'b0;
    end else begin
      backup_access_clk_en <= tick(div_cnt_q, backup_shift); // [R04]
    end
  end

  // settings driven to the oscillator and controller
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_cfg <= '0;
    end else begin
      trim_cfg.coarse <= coarse_q;
      trim_cfg.fine <= fine_q; // [R11]
      trim_cfg.ref_sel <= refsel_q; // [R14]
      trim_cfg.mode <= mode_q; // [R15]
      trim_cfg.atc_run <= atc_en_q && trim_en_q; // [R16] [R17]
      trim_cfg.trim_en <= trim_en_q; // [R17]
    end
  end

endmodule : acp_clock_prescale_trim
`default_nettype wire

// ==== test/acp_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module acp_properties import acp_pkg::*; #(
  parameter int DIV_CNT_W = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ACP_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [ACP_COARSE_W-1:0] factory_coarse,
  input wire logic [ACP_FINE_W-1:0] factory_fine,
  input wire acp_atc_t atc_status,
  input wire logic [ACP_NUM_STD-1:0] periph_clk_en,
  input wire logic backup_access_clk_en,
  input wire acp_trim_t trim_cfg,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // setup phase of a transfer
  wire su = psel & ~penable;
  AST_READY: assert property (su |=> pready) else $error("no ready after setup");
  AST_ONE_ACCESS: assert property (pready |=> !pready) else $error("ready held");
  AST_UNMAPPED: assert property (su && paddr == 12'h100 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_PRESCALE_RSVD: assert property (su && !pwrite && paddr == ACP_OFF_PRESCALE
    |=> !pslverr && (prdata & ~ACP_PRESCALE_WMASK) == 32'h0) else $error("reserved set");
  AST_WRITE_ZERO: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data on write");
  // three edges of history: the factory load and its registered copy stay out of reach
  AST_COARSE_FIXED: assert property ($past(presetn) && $past(presetn, 2) && $past(presetn, 3)
    |-> $stable(trim_cfg.coarse)) else $error("coarse trim moved");
  AST_COUNT_RSVD: assert property (su && !pwrite && paddr == ACP_OFF_TRIM_CNT
    |=> prdata[31:14] == 18'h0) else $error("counter upper bits set");
  AST_BACKUP_MIN: assert property (backup_access_clk_en
    |=> !backup_access_clk_en [*3]) else $error("backup pulse too close");
  AST_BACKUP_MAX: assert property (backup_access_clk_en
    |-> ##[1:32] backup_access_clk_en) else $error("backup pulse missing");
  AST_AUDIO_MAX: assert property (periph_clk_en[7]
    |-> ##[1:8] periph_clk_en[7]) else $error("audio pulse missing");
endmodule : acp_properties
bind acp_clock_prescale_trim acp_properties #(.DIV_CNT_W(DIV_CNT_W)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .factory_coarse(factory_coarse), .factory_fine(factory_fine), .atc_status(atc_status),
  .periph_clk_en(periph_clk_en), .backup_access_clk_en(backup_access_clk_en),
  .trim_cfg(trim_cfg), .irq(irq));
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import acp_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, bkp, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [4:0] fc;
  logic [7:0] ff, f, g, pen;
  logic [13:0] cv;
  acp_atc_t auto_trim_controller;
  acp_trim_t tcfg;
  int errors, checked, cyc, b;
  int cnt[8];
  int pos[8] = '{0, 2, 4, 8, 12, 16, 18, 20};

  acp_clock_prescale_trim #(.DIV_CNT_W(5)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .factory_coarse(fc), .factory_fine(ff), .atc_status(auto_trim_controller), .periph_clk_en(pen),
    .backup_access_clk_en(bkp), .trim_cfg(tcfg), .irq(irq));

  // clock and a ceiling well above the few hundred cycles needed
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // request held until the rising edge that samples pready high; the cycle ceiling ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc

  // one-cycle fine load from the trim controller side
  task automatic load(input logic [7:0] x);
    @(posedge pclk);
    auto_trim_controller.fine_load <= 1'b1;
    auto_trim_controller.fine_value <= x;
    @(posedge pclk);
    auto_trim_controller.fine_load <= 1'b0;
  endtask : load

  // expected trim control word; coarse always the factory value
  function automatic logic [31:0] ctl(logic [7:0] fv, logic [1:0] r, logic m, logic a, logic t);
    return {3'h0, fc, fv, 8'h0, 1'b0, r, m, 2'h0, a, t};
  endfunction : ctl

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    presetn = 1'b0;
    auto_trim_controller = '0;
    void'($urandom(66856));
    fc = 5'($urandom);
    ff = 8'($urandom);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ACP_OFF_PRESCALE, 32'h0);
    rdc(ACP_OFF_TRIM_CTRL, ctl(ff, 2'h0, 1'b0, 1'b0, 1'b0));
    rdc(12'h100, 32'h0);
    chk(er, 1'b1);
    // codes staggered per field so a swapped field shows up
    for (int c = 0; c < 4; c++) begin
      v = '0;
      for (int k = 0; k < 8; k++) v[pos[k] +: 2] = 2'((c + k) % 4);
      v[15:14] = 2'(c);
      apb(1'b1, ACP_OFF_PRESCALE, v | (32'($urandom) & ~ACP_PRESCALE_WMASK));
      rdc(ACP_OFF_PRESCALE, v);
      cnt = '{default: 0};
      b = 0;
      repeat (32) begin
        @(negedge pclk);
        for (int k = 0; k < 8; k++) cnt[k] += pen[k];
        b += bkp;
      end
      for (int k = 0; k < 8; k++) begin
        chk(cnt[k], 32 >> ((c + k) % 4));
      end
      chk(b, 8 >> c);
    end
    // manual mode: software owns fine, controller loads ignored
    for (int r = 0; r < 4; r++) begin
      f = 8'($urandom);
      apb(1'b1, ACP_OFF_TRIM_CTRL, ctl(f, 2'(r), 1'b1, 1'b1, 1'b1) | 32'hff00ff8c);
      load(~f);
      rdc(ACP_OFF_TRIM_CTRL, ctl(f, 2'(r), 1'b1, 1'b1, 1'b1));
      chk({tcfg.coarse, tcfg.fine, tcfg.ref_sel, tcfg.mode, tcfg.trim_en}, {fc, f, 2'(r), 2'b11});
    end
    // automatic mode: controller owns fine, event masked
    apb(1'b1, ACP_OFF_IRQ_MASK, 32'h0);
    apb(1'b1, ACP_OFF_TRIM_CTRL, ctl(f, 2'h2, 1'b0, 1'b1, 1'b1));
    g = 8'($urandom);
    load(g);
    rdc(ACP_OFF_TRIM_CTRL, ctl(g, 2'h2, 1'b0, 1'b1, 1'b1));
    chk(irq, 1'b0);
    rdc(ACP_OFF_IRQ_STATUS, 32'h4);
    rdc(ACP_OFF_IRQ_STATUS, 32'h0);
    apb(1'b1, ACP_OFF_IRQ_MASK, 32'h7);
    apb(1'b1, ACP_OFF_TRIM_CTRL, ctl(~g, 2'h2, 1'b0, 1'b1, 1'b1));
    auto_trim_controller.locked <= 1'b1;
    repeat (4) @(negedge pclk);
    chk(irq, 1'b1);
    rdc(ACP_OFF_TRIM_CTRL, ctl(g, 2'h2, 1'b0, 1'b1, 1'b1) | 32'h80);
    rdc(ACP_OFF_IRQ_STATUS, 32'h1);
    repeat (2) @(negedge pclk);
    chk(irq, 1'b0);
    @(posedge pclk);
    cv = 14'($urandom);
    auto_trim_controller.count <= cv;
    auto_trim_controller.locked <= 1'b0;
    repeat (4) @(negedge pclk);
    rdc(ACP_OFF_IRQ_STATUS, 32'h2);
    rdc(ACP_OFF_TRIM_CNT, {18'h0, cv});
    // trimming off: controller may no longer touch fine
    apb(1'b1, ACP_OFF_TRIM_CTRL, ctl(g, 2'h2, 1'b0, 1'b1, 1'b0));
    load(~g);
    rdc(ACP_OFF_TRIM_CTRL, ctl(g, 2'h2, 1'b0, 1'b1, 1'b0));
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ACP_OFF_PRESCALE, 32'h0);
    chk(irq, 1'b0);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
